//--- rim_pkg.sv
package rim_pkg;
   localparam logic [15:0] RESET_VECTOR_ADDR = 16'hFFFE;
   localparam int NUM_MI = 8;
   localparam int NUM_NMI = 4;
   localparam int NUM_RST = 8;
   localparam int BOOT_CYCLES = 16;
   localparam logic [4:0] BOOT_CNT_INIT = 5'h10;
   localparam logic [5:0] ADDR_CTRL = 6'h00;
   localparam logic [5:0] ADDR_MIE = 6'h01;
   localparam logic [5:0] ADDR_NMIE = 6'h02;
   localparam logic [5:0] ADDR_RSTCAUSE = 6'h03;
   localparam logic [5:0] ADDR_MIFG = 6'h04;
   localparam logic [5:0] ADDR_NMIFG = 6'h05;
   localparam logic [5:0] ADDR_IRQ_STAT = 6'h06;
   localparam logic [5:0] ADDR_IRQ_CLR = 6'h07;
   localparam logic [5:0] ADDR_IRQ_EN = 6'h08;
   localparam logic [5:0] ADDR_SUPPLY = 6'h09;
   localparam logic [5:0] ADDR_VECTOR = 6'h0A;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] UNMAPPED_DATA = 32'hDEAD_BEEF;
   // reset cause bit positions
   localparam int RC_POWERUP = 0;
   localparam int RC_PIN = 1;
   localparam int RC_WAKE = 2;
   localparam int RC_WDT = 3;
   localparam int RC_PASSWD = 4;
   localparam int RC_SUPERVISOR = 5;
   localparam int RC_MONITOR = 6;
   localparam int RC_SOFTWARE = 7;
   // irq status bits
   localparam int EV_RESET = 0;
   localparam int EV_NMI = 1;
   localparam int EV_OVERVOLT = 2;
   localparam int EV_TAKEN = 3;

   typedef struct packed {
      logic powerup;
      logic pin;
      logic wake;
      logic wdt;
      logic passwd;
      logic sup_under;
      logic mon_under;
      logic mon_over;
      logic sw_reset;
   } rim_events_s;

   typedef struct packed {
      logic req;
      logic [1:0] cls;
      logic [3:0] src;
   } rim_service_s;

   localparam logic [1:0] CLS_NONE = 2'h0;
   localparam logic [1:0] CLS_RESET = 2'h1;
   localparam logic [1:0] CLS_NMI = 2'h2;
   localparam logic [1:0] CLS_MASK = 2'h3;

   function automatic logic [3:0] rim_lowest(input logic [7:0] v);
      logic [3:0] r;
      r = 4'hF;
      for (int i = 7; i >= 0; i--) begin
         if (v[i]) begin
            r = 4'(i);
         end
      end
      return r;
   endfunction
endpackage

//--- rim_arbiter.sv
`timescale 1ns/100ps
`default_nettype none
module rim_arbiter (
   input wire logic reset_pend,
   input wire logic [rim_pkg::NUM_NMI-1:0] nmi_pend,
   input wire logic [rim_pkg::NUM_MI-1:0] mi_pend,
   input wire logic [rim_pkg::NUM_NMI-1:0] nmi_en,
   input wire logic [rim_pkg::NUM_MI-1:0] mi_en,
   input wire logic gate,
   output var rim_pkg::rim_service_s svc
);
   import rim_pkg::*;
   logic [NUM_NMI-1:0] nmi_act;
   logic [NUM_MI-1:0] mi_act;
   assign nmi_act = nmi_pend & nmi_en;
   assign mi_act = mi_pend & mi_en & {NUM_MI{gate}};
   always_comb begin
      svc = '0;
      if (reset_pend) begin
         svc.req = 1'b1;
         svc.cls = CLS_RESET;
      end else if (|nmi_act) begin
         svc.req = 1'b1;
         svc.cls = CLS_NMI;
         svc.src = rim_lowest({4'h0, nmi_act});
      end else if (|mi_act) begin
         svc.req = 1'b1;
         svc.cls = CLS_MASK;
         svc.src = rim_lowest(mi_act);
      end
   end
endmodule
`default_nettype wire

//--- rim_top.sv
`timescale 1ns/100ps
`default_nettype none
module rim_top (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic supply_good,
   input wire rim_pkg::rim_events_s events,
   input wire logic [rim_pkg::NUM_NMI-1:0] nmi_src,
   input wire logic [rim_pkg::NUM_MI-1:0] mi_src,
   input wire logic svc_ack,
   input wire logic [15:0] vector_data,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic active_mode,
   output logic cpu_reset,
   output logic calib_load,
   output logic vector_fetch,
   output logic [15:0] vector_addr,
   output logic [15:0] pc_load,
   output logic pc_load_valid,
   output logic svc_req,
   output logic [1:0] svc_class,
   output logic [3:0] svc_src,
   output logic irq
);
   import rim_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // reset release and pin synchronisers
   logic rs1_q, rs2_q;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rs1_q <= 1'b0;
         rs2_q <= 1'b0;
      end else begin
         rs1_q <= 1'b1;
         rs2_q <= rs1_q;
      end
   end
   wire logic rn = rs2_q;

   logic [8:0] ev1_q, ev2_q;
   logic [NUM_NMI-1:0] n1_q, n2_q;
   logic [NUM_MI-1:0] m1_q, m2_q;
   logic sg1_q, sg2_q;
   always_ff @(posedge clock or negedge rn) begin
      if (!rn) begin
         ev1_q <= '0;
         ev2_q <= '0;
         n1_q <= '0;
         n2_q <= '0;
         m1_q <= '0;
         m2_q <= '0;
         sg1_q <= 1'b0;
         sg2_q <= 1'b0;
      end else begin
         ev1_q <= events;
         ev2_q <= ev1_q;
         n1_q <= nmi_src;
         n2_q <= n1_q;
         m1_q <= mi_src;
         m2_q <= m1_q;
         sg1_q <= supply_good;
         sg2_q <= sg1_q;
      end
   end
   rim_events_s ev;
   assign ev = ev2_q;

   ////////////////////////////////////////////////////////////////////////////
   // control registers
   logic gate_q;
   logic sup_rst_q, mon_rst_q;
   logic [NUM_MI-1:0] mie_q;
   logic [NUM_NMI-1:0] nmie_q;
   logic [3:0] irq_en_q;
   logic wr_ok;
   assign wr_ok = avs_write && avs_waitrequest == 1'b0;

   always_ff @(posedge clock or negedge rn) begin
      if (!rn) begin
         gate_q <= 1'b0;
         sup_rst_q <= 1'b1;
         mon_rst_q <= 1'b0;
         mie_q <= '0;
         nmie_q <= '0;
         irq_en_q <= '0;
      end else if (wr_ok && avs_byteenable[0]) begin
         unique case (avs_address)
            ADDR_CTRL: begin
               gate_q <= avs_writedata[0];
               sup_rst_q <= avs_writedata[1];
               mon_rst_q <= avs_writedata[2];
            end
            ADDR_MIE: mie_q <= avs_writedata[NUM_MI-1:0];
            ADDR_NMIE: nmie_q <= avs_writedata[NUM_NMI-1:0];
            ADDR_IRQ_EN: irq_en_q <= avs_writedata[3:0];
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // reset trigger collection
   logic brownout, puc_trig, sys_trig;
   assign brownout = !sg2_q;
   assign puc_trig = ev.wdt | ev.passwd | (ev.mon_under & mon_rst_q)
      | (ev.sup_under & sup_rst_q) | ev.sw_reset;
   assign sys_trig = ev.powerup | ev.pin | ev.wake | puc_trig;
   logic bor_class;
   assign bor_class = brownout | ev.powerup | ev.pin | ev.wake;

   ////////////////////////////////////////////////////////////////////////////
   // reset sequencer
   typedef enum logic [3:0] {
      RIM_HOLD = 4'b0001,
      RIM_BOOT = 4'b0010,
      RIM_FETCH = 4'b0100,
      RIM_RUN = 4'b1000
   } rim_state_e;
   rim_state_e st_q;
   logic [4:0] boot_cnt_q;
   logic boot_need_q;

   always_ff @(posedge clock or negedge rn) begin
      if (!rn) begin
         st_q <= RIM_HOLD;
         boot_cnt_q <= '0;
         boot_need_q <= 1'b1;
      end else if (brownout) begin
         st_q <= RIM_HOLD;
         boot_need_q <= 1'b1;
      end else if (sys_trig) begin
         st_q <= RIM_HOLD;
         boot_need_q <= boot_need_q | bor_class;
      end else begin
         unique case (st_q)
            RIM_HOLD: begin
               st_q <= boot_need_q ? RIM_BOOT : RIM_FETCH;
               boot_cnt_q <= BOOT_CNT_INIT;
            end
            RIM_BOOT: begin
               boot_cnt_q <= boot_cnt_q - 5'h01;
               if (boot_cnt_q == 5'h01) begin
                  st_q <= RIM_FETCH;
                  boot_need_q <= 1'b0;
               end
            end
            RIM_FETCH: st_q <= RIM_RUN;
            RIM_RUN: ;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rn) begin
      if (!rn) begin
         cpu_reset <= 1'b1;
         active_mode <= 1'b0;
         calib_load <= 1'b0;
         vector_fetch <= 1'b0;
         vector_addr <= '0;
         pc_load <= '0;
         pc_load_valid <= 1'b0;
      end else begin
         cpu_reset <= st_q != RIM_RUN;
         calib_load <= st_q == RIM_BOOT;
         vector_fetch <= st_q == RIM_FETCH;
         vector_addr <= RESET_VECTOR_ADDR;
         // vector word taken while the fetch strobe stands
         pc_load_valid <= vector_fetch && st_q == RIM_RUN;
         if (vector_fetch && st_q == RIM_RUN) begin
            pc_load <= vector_data;
            active_mode <= 1'b1;
         end else if (st_q != RIM_RUN) begin
            active_mode <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // reset cause flags
   logic [NUM_RST-1:0] cause_q;
   logic [NUM_RST-1:0] cause_set;
   always_comb begin
      cause_set = '0;
      cause_set[RC_POWERUP] = ev.powerup | brownout;
      cause_set[RC_PIN] = ev.pin;
      cause_set[RC_WAKE] = ev.wake;
      cause_set[RC_WDT] = ev.wdt;
      cause_set[RC_PASSWD] = ev.passwd;
      cause_set[RC_SUPERVISOR] = ev.sup_under & sup_rst_q;
      cause_set[RC_MONITOR] = ev.mon_under & mon_rst_q;
      cause_set[RC_SOFTWARE] = ev.sw_reset;
   end
   always_ff @(posedge clock or negedge rn) begin
      if (!rn) begin
         cause_q <= '0;
      end else begin
         // set wins over software clear
         cause_q <= (cause_q & ~((wr_ok && avs_address == ADDR_RSTCAUSE)
            ? avs_writedata[NUM_RST-1:0] : '0)) | cause_set;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pending flags and arbitration
   logic [NUM_MI-1:0] mifg_q;
   logic [NUM_NMI-1:0] nmifg_q;
   logic [NUM_NMI-1:0] nmi_in;
   assign nmi_in = {n2_q[NUM_NMI-1:2], n2_q[1] | ev.mon_over,
      n2_q[0] | (ev.sup_under & !sup_rst_q) | (ev.mon_under & !mon_rst_q)};
   rim_service_s svc;
   rim_arbiter u_arb (
      .reset_pend(st_q != RIM_RUN),
      .nmi_pend(nmifg_q),
      .mi_pend(mifg_q),
      .nmi_en(nmie_q),
      .mi_en(mie_q),
      .gate(gate_q),
      .svc(svc)
   );
   logic ack_nmi, ack_mi;
   assign ack_nmi = svc_ack && svc.cls == CLS_NMI;
   assign ack_mi = svc_ack && svc.cls == CLS_MASK;

   always_ff @(posedge clock or negedge rn) begin
      if (!rn) begin
         mifg_q <= '0;
         nmifg_q <= '0;
      end else begin
         mifg_q <= (mifg_q
            & ~(ack_mi ? NUM_MI'(1) << svc.src[2:0] : '0)
            & ~((wr_ok && avs_address == ADDR_MIFG) ? avs_writedata[NUM_MI-1:0] : '0))
            | m2_q;
         nmifg_q <= (nmifg_q
            & ~(ack_nmi ? NUM_NMI'(1) << svc.src[1:0] : '0)
            & ~((wr_ok && avs_address == ADDR_NMIFG) ? avs_writedata[NUM_NMI-1:0] : '0))
            | nmi_in;
      end
   end

   always_ff @(posedge clock or negedge rn) begin
      if (!rn) begin
         svc_req <= 1'b0;
         svc_class <= CLS_NONE;
         svc_src <= '0;
      end else begin
         svc_req <= svc.req && st_q == RIM_RUN;
         svc_class <= svc.cls;
         svc_src <= svc.src;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // event status, enable, clear and irq
   logic [3:0] ist_q, iset;
   assign iset = {ack_nmi | ack_mi, ev.mon_over, |nmi_in, sys_trig};
   always_ff @(posedge clock or negedge rn) begin
      if (!rn) begin
         ist_q <= '0;
         irq <= 1'b0;
      end else begin
         ist_q <= (ist_q & ~((wr_ok && avs_address == ADDR_IRQ_CLR)
            ? avs_writedata[3:0] : 4'h0)) | iset;
         irq <= |(ist_q & irq_en_q);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // avalon slave: one wait cycle then answer
   logic busy_q;
   always_ff @(posedge clock or negedge rn) begin
      if (!rn) begin
         busy_q <= 1'b0;
         avs_waitrequest <= 1'b1;
      end else begin
         busy_q <= (avs_read | avs_write) && avs_waitrequest && !busy_q;
         avs_waitrequest <= !((avs_read | avs_write) && avs_waitrequest && !busy_q);
      end
   end

   always_ff @(posedge clock or negedge rn) begin
      if (!rn) begin
         avs_readdata <= '0;
      end else if (avs_read && avs_waitrequest && !busy_q) begin
         unique case (avs_address)
            ADDR_CTRL: avs_readdata <= {29'h0, mon_rst_q, sup_rst_q, gate_q};
            ADDR_MIE: avs_readdata <= {24'h0, mie_q};
            ADDR_NMIE: avs_readdata <= {28'h0, nmie_q};
            ADDR_RSTCAUSE: avs_readdata <= {24'h0, cause_q};
            ADDR_MIFG: avs_readdata <= {24'h0, mifg_q};
            ADDR_NMIFG: avs_readdata <= {28'h0, nmifg_q};
            ADDR_IRQ_STAT: avs_readdata <= {28'h0, ist_q};
            ADDR_IRQ_EN: avs_readdata <= {28'h0, irq_en_q};
            ADDR_SUPPLY: avs_readdata <= {30'h0, ev.mon_over, sg2_q};
            ADDR_VECTOR: avs_readdata <= {16'h0, pc_load};
            default: avs_readdata <= UNMAPPED_DATA;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   AST_VEC_ADDR: assert property (@(posedge clock) disable iff (!rn)
      vector_fetch |-> vector_addr == RESET_VECTOR_ADDR)
      else $error("vector address wrong");
   AST_BOOT_FIRST: assert property (@(posedge clock) disable iff (!rn)
      $rose(calib_load) |-> ##16 !calib_load || sys_trig || brownout)
      else $error("boot code length wrong");
   AST_GATE: assert property (@(posedge clock) disable iff (!rn)
      svc_req && svc_class == CLS_MASK |-> $past(gate_q))
      else $error("maskable served with gate closed");
   AST_PRIO: assert property (@(posedge clock) disable iff (!rn)
      (st_q != RIM_RUN) |-> svc.cls == CLS_RESET)
      else $error("reset class not first");
   AST_NMI_EN: assert property (@(posedge clock) disable iff (!rn)
      svc.cls == CLS_NMI |-> nmie_q[svc.src[1:0]])
      else $error("disabled nmi served");
   AST_CAUSE: assert property (@(posedge clock) disable iff (!rn)
      ev.wdt |=> cause_q[RC_WDT])
      else $error("watchdog cause missed");
   AST_HOLD: assert property (@(posedge clock) disable iff (!rn)
      brownout |-> ##2 cpu_reset ##1 cpu_reset)
      else $error("brownout did not hold reset");
   AST_STICKY: assert property (@(posedge clock) disable iff (!rn)
      mifg_q != '0 && !svc_ack && !wr_ok |=> (mifg_q & $past(mifg_q)) == $past(mifg_q))
      else $error("flag lost");
   AST_OVER: assert property (@(posedge clock) disable iff (!rn)
      ev.mon_over |=> ist_q[EV_OVERVOLT])
      else $error("overvoltage not flagged");
endmodule
`default_nettype wire

//--- rim_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
module rim_cpu_model #(
   parameter logic [15:0] START = 16'h4400
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic vector_fetch,
   input wire logic [15:0] vector_addr,
   input wire logic svc_req,
   input wire logic [1:0] svc_class,
   input wire logic [3:0] svc_src,
   input wire logic ack_en,
   output logic [15:0] vector_data,
   output logic svc_ack,
   output logic [5:0] taken
);
   logic [1:0] wait_q;
   // start word only while the vector word is addressed
   assign vector_data = (vector_fetch && vector_addr == 16'hFFFE) ? START : ~START;
   // one ack per request, then a pause for the flag to clear
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         svc_ack <= 1'b0;
         wait_q <= 2'h0;
         taken <= 6'h0;
      end else begin
         svc_ack <= 1'b0;
         if (wait_q != 2'h0) begin
            wait_q <= wait_q - 2'h1;
         end else if (svc_req && ack_en) begin
            svc_ack <= 1'b1;
            taken <= {svc_class, svc_src};
            wait_q <= 2'h3;
         end
      end
   end
endmodule
`default_nettype wire

//--- tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
   import rim_pkg::*;
   localparam logic [15:0] START = 16'h4400;
   logic clock, rst_n, supply_good, avs_read, avs_write, ack_en;
   logic avs_waitrequest, active_mode, cpu_reset, calib_load, vector_fetch;
   logic pc_load_valid, svc_req, svc_ack, irq;
   logic [8:0] ev_v;
   logic [3:0] nmi_src, avs_byteenable, svc_src;
   logic [7:0] mi_src;
   logic [5:0] avs_address, taken;
   logic [1:0] svc_class;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic [15:0] vector_data, vector_addr, pc_load;
   int errors = 0;
   int tests_run = 0;
   int cycles = 0;
   rim_top DUT (
      .clock(clock), .rst_n(rst_n), .supply_good(supply_good),
      .events(rim_events_s'(ev_v)), .nmi_src(nmi_src), .mi_src(mi_src),
      .svc_ack(svc_ack), .vector_data(vector_data), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .active_mode(active_mode),
      .cpu_reset(cpu_reset), .calib_load(calib_load), .vector_fetch(vector_fetch),
      .vector_addr(vector_addr), .pc_load(pc_load), .pc_load_valid(pc_load_valid),
      .svc_req(svc_req), .svc_class(svc_class), .svc_src(svc_src), .irq(irq)
   );
   rim_cpu_model #(.START(START)) cpu (
      .clock(clock), .rst_n(rst_n), .vector_fetch(vector_fetch),
      .vector_addr(vector_addr), .svc_req(svc_req), .svc_class(svc_class),
      .svc_src(svc_src), .ack_en(ack_en), .vector_data(vector_data),
      .svc_ack(svc_ack), .taken(taken)
   );
   ////////////////////////////////
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == 30000) begin
         errors++;
         tally_and_finish();
      end
   end
   ////////////////////////////////
   task automatic tally_and_finish;
      $display("tests_run %0d errors %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask
   // one avalon transfer, held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !w;
      avs_write <= w;
      do begin
         @(posedge clock);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 50) errors++;
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rd(input logic [5:0] a);
      bus(1'b0, a, 32'h0);
   endtask
   task automatic pulse(input int i);
      @(posedge clock);
      ev_v[i] <= 1'b1;
      cyc(3);
      ev_v[i] <= 1'b0;
   endtask
   // follow one system reset through vector fetch, with boot only when boot is set
   task automatic sys_wait(input logic boot);
      logic sr, sb, fb, pv;
      sr = 0;
      sb = 0;
      fb = 0;
      pv = 0;
      for (int i = 0; i < 400 && !(sr && cpu_reset === 1'b0 && active_mode === 1'b1); i++) begin
         @(posedge clock);
         if (cpu_reset === 1'b1) sr = 1;
         if (calib_load === 1'b1) sb = 1;
         if (vector_fetch === 1'b1 && !sb) fb = 1;
         if (pc_load_valid === 1'b1) pv = 1;
      end
      chk("pcvalid", pv, 1'b1);
      chk("active", {sr, active_mode, cpu_reset}, 3'b110);
      chk("boot", sb, boot);
      chk("order", fb, !boot);
      chk("pc", pc_load, START);
   endtask
   ////////////////////////////////
   task automatic t_boot;
      sys_wait(1'b1);
      rd(ADDR_MIE);
      chk("mie", q, 32'h0);
      rd(ADDR_NMIE);
      chk("nmie", q, 32'h0);
      rd(6'h3F);
      chk("unmapped", q, 32'hDEADBEEF);
      rd(ADDR_CTRL);
      chk("ctrl", q, 32'h2);
      rd(ADDR_SUPPLY);
      chk("supply", q, 32'h1);
      rd(ADDR_VECTOR);
      chk("vector", q, {16'h0, START});
      $display("test boot done");
   endtask
   task automatic t_causes;
      int evi [8] = '{8, 7, 6, 5, 4, 3, 2, 0};
      for (int i = 0; i < 8; i++) begin
         wr(ADDR_CTRL, 32'h6);
         wr(ADDR_RSTCAUSE, 32'hFF);
         pulse(evi[i]);
         sys_wait(i < 3);
         rd(ADDR_RSTCAUSE);
         chk("cause", q, 32'h1 << i);
      end
      $display("test causes done");
   endtask
   task automatic t_brown;
      logic bad;
      bad = 0;
      wr(ADDR_RSTCAUSE, 32'hFF);
      supply_good <= 1'b0;
      cyc(6);
      repeat (40) begin
         @(posedge clock);
         if (cpu_reset !== 1'b1) bad = 1;
      end
      chk("hold", bad, 1'b0);
      supply_good <= 1'b1;
      sys_wait(1'b1);
      rd(ADDR_RSTCAUSE);
      chk("bcause", q, 32'h1);
      $display("test brownout done");
   endtask
   task automatic take(input logic [5:0] e);
      int n;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (svc_ack !== 1'b1 && n < 60);
      chk("taken", taken, e);
   endtask
   task automatic t_prio;
      wr(ADDR_MIE, 32'hFF);
      wr(ADDR_NMIE, 32'h0);
      wr(ADDR_CTRL, 32'h2);
      @(posedge clock);
      mi_src <= 8'h24;
      nmi_src <= 4'h8;
      cyc(4);
      mi_src <= 8'h0;
      nmi_src <= 4'h0;
      cyc(6);
      chk("gated", svc_req, 1'b0);
      rd(ADDR_MIFG);
      chk("mifg", q, 32'h24);
      wr(ADDR_NMIE, 32'h8);
      cyc(4);
      chk("nmi", {svc_req, svc_class, svc_src}, {1'b1, CLS_NMI, 4'h3});
      wr(ADDR_CTRL, 32'h3);
      @(posedge clock);
      ack_en <= 1'b1;
      take({CLS_NMI, 4'h3});
      take({CLS_MASK, 4'h2});
      take({CLS_MASK, 4'h5});
      cyc(6);
      ack_en <= 1'b0;
      chk("idle", svc_req, 1'b0);
      $display("test priority done");
   endtask
   task automatic t_supply;
      wr(ADDR_CTRL, 32'h1);
      wr(ADDR_NMIE, 32'h0);
      wr(ADDR_NMIFG, 32'hF);
      wr(ADDR_IRQ_CLR, 32'hF);
      wr(ADDR_IRQ_EN, 32'h4);
      pulse(1);
      cyc(5);
      chk("irq", irq, 1'b1);
      pulse(2);
      pulse(3);
      cyc(6);
      chk("norst", cpu_reset, 1'b0);
      rd(ADDR_NMIFG);
      chk("nmifg", q, 32'h3);
      rd(ADDR_IRQ_STAT);
      chk("evstat", q, 32'h6);
      wr(ADDR_IRQ_EN, 32'h0);
      cyc(2);
      chk("masked", irq, 1'b0);
      wr(ADDR_IRQ_EN, 32'h4);
      cyc(2);
      chk("unmask", irq, 1'b1);
      wr(ADDR_IRQ_CLR, 32'h4);
      cyc(2);
      chk("cleared", irq, 1'b0);
      rd(ADDR_IRQ_STAT);
      chk("stat", q & 32'h4, 32'h0);
      $display("test supply done");
   endtask
   ////////////////////////////////
   initial begin
      rst_n = 1'b0;
      supply_good = 1'b1;
      ev_v = 9'h0;
      nmi_src = 4'h0;
      mi_src = 8'h0;
      avs_address = 6'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hF;
      ack_en = 1'b0;
      repeat (8) @(posedge clock);
      rst_n <= 1'b1;
      t_boot();
      t_causes();
      t_brown();
      t_prio();
      t_supply();
      tally_and_finish();
   end
endmodule
`default_nettype wire
